// ---- rtl/host_port_defs.svh ----
// Constants for the host port pin isolation block
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ****************************************************************
// Interface pin roles, one bit each in the role vectors
// ****************************************************************
`define ROLE_RDY 0
`define ROLE_IRQ 1
`define ROLE_XREQ 2
`define ROLE_DATA 3
`define ROLE_SEL 4
`define ROLE_RSEL 5
`define ROLE_WR 6
`define ROLE_RD 7
`define ROLE_N 8

// ****************************************************************
// Bit positions in the pin synchroniser vector
// ****************************************************************
`define SYN_RES 0
`define SYN_BOOT 1
`define SYN_ISO 2
`define SYN_SEL 3
`define SYN_RSEL 4
`define SYN_WR 5
`define SYN_RD 6
`define SYN_D_LO 7
`define SYN_D_HI 22
`define SYN_W 23

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define DATA_W 16
`define DATA_RST 16'h0000
`define ROLE_RST 8'h00
`define STROBE_RST 4'h0
`define SYN_RST 23'h000000

`endif

// ---- rtl/host_port_pkg.sv ----
// Types shared by the host port pin isolation block
package host_port_pkg;

    // Main state: reset pin held, or reset released
    typedef enum logic {
        ST_RESET = 1'b0,
        ST_RUN = 1'b1
    } pin_state_t;

endpackage : host_port_pkg

// ---- rtl/pin_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"

module pin_sync3 (
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    input wire logic [`SYN_W-1:0] pin_in,
    output logic [`SYN_W-1:0] pin_out
);

    logic [`SYN_W-1:0] st1_reg;
    logic [`SYN_W-1:0] st2_reg;
    logic [`SYN_W-1:0] st3_reg;
    logic [`SYN_W-1:0] out_reg;
    logic [`SYN_W-1:0] out_next;

    // ****************************************************************
    // Filter: a bit changes only once stages two and three agree
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `SYN_W; gi = gi + 1) begin : g_filt
            always_comb begin
                out_next[gi] = (st2_reg[gi] == st3_reg[gi]) ? st3_reg[gi] : out_reg[gi];
            end
        end
    endgenerate

    // Stage one feeds only stage two
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st1_reg <= `SYN_RST;
            st2_reg <= `SYN_RST;
            st3_reg <= `SYN_RST;
            out_reg <= `SYN_RST;
        end else begin
            st1_reg <= pin_in;
            st2_reg <= st1_reg;
            st3_reg <= st2_reg;
            out_reg <= out_next;
        end
    end

    assign pin_out = out_reg;

endmodule : pin_sync3
`default_nettype wire

// ---- rtl/host_port_pin_isolation.sv ----
// Buffer enable control for the parallel host port pins
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"

module host_port_pin_isolation (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reset_pin_b,
    input wire logic boot_select_in,
    input wire logic iso_enable_in,
    input wire logic pfc_iso_sel,
    input wire logic [`ROLE_N-1:0] pin_function_select,
    input wire logic seq_ready,
    input wire logic seq_irq,
    input wire logic seq_xfer_req,
    input wire logic [`DATA_W-1:0] core_rdata,
    output logic host_ready_out,
    output logic host_ready_oe_b,
    output logic host_irq_out,
    output logic host_irq_oe_b,
    output logic host_xfer_req_out,
    output logic host_xfer_req_oe_b,
    input wire logic [`DATA_W-1:0] host_data_in,
    output logic [`DATA_W-1:0] host_data_out,
    output logic host_data_oe_b,
    input wire logic host_select_in,
    input wire logic host_regsel_in,
    input wire logic host_write_strobe,
    input wire logic host_read_strobe,
    output logic [3:0] core_strobes,
    output logic [`DATA_W-1:0] core_wdata,
    output logic [`ROLE_N-1:0] buf_enable,
    output logic [3:0] gp_strobe_in,
    output logic [`DATA_W-1:0] gp_data_in,
    output logic gp_iso_in,
    output logic run_boot_mode
);
    import host_port_pkg::*;

    // ****************************************************************
    // Reset release and pin synchronisation
    // ****************************************************************
    logic rst_m_reg;
    logic rst_sync_b;
    logic [`SYN_W-1:0] syn_in;
    logic [`SYN_W-1:0] syn;

    // Two-flop release of the async reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_m_reg <= 1'b1;
            rst_sync_b <= rst_m_reg;
        end
    end

    assign syn_in = {host_data_in, host_read_strobe, host_write_strobe, host_regsel_in,
                     host_select_in, iso_enable_in, boot_select_in, reset_pin_b};

    pin_sync3 u_sync (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b),
        .pin_in(syn_in),
        .pin_out(syn)
    );

    logic iso_s;
    logic boot_s;
    logic [3:0] strb_s;
    logic [`DATA_W-1:0] data_s;
    assign iso_s = syn[`SYN_ISO];
    assign boot_s = syn[`SYN_BOOT];
    assign strb_s = syn[`SYN_RD:`SYN_SEL];
    assign data_s = syn[`SYN_D_HI:`SYN_D_LO];

    // ****************************************************************
    // Main state and boot strap
    // ****************************************************************
    pin_state_t state_reg;
    pin_state_t state_next;
    logic boot_mode_reg;
    logic boot_mode_next;

    // Strap follows the pin while reset is held, then is frozen
    always_comb begin
        state_next = syn[`SYN_RES] ? ST_RUN : ST_RESET;
        boot_mode_next = (state_reg == ST_RESET) ? boot_s : boot_mode_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg <= ST_RESET;
            boot_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            boot_mode_reg <= boot_mode_next;
        end
    end

    // ****************************************************************
    // Buffer enables and pin outputs
    // ****************************************************************
    logic [`ROLE_N-1:0] role_on;
    logic gate;
    logic [`ROLE_N-1:0] en;
    logic rd_access;
    logic rdy_out_next, rdy_oe_b_next, irq_out_next, irq_oe_b_next;
    logic xreq_out_next, xreq_oe_b_next, data_oe_b_next, gp_iso_next;
    logic [`DATA_W-1:0] data_out_next, wdata_next, gp_data_next;
    logic [3:0] strobes_next, gp_strobe_next;
    logic [3:0] strb_en;

    always_comb begin
        role_on = `ROLE_RST;
        gate = 1'b0;
        if (state_reg == ST_RUN) begin
            if (boot_mode_reg) begin
                role_on = {`ROLE_N{1'b1}};
                gate = iso_s;
            end else begin
                role_on = pin_function_select;
                gate = pfc_iso_sel & iso_s;
            end
        end
        en = role_on & {`ROLE_N{gate}};
        strb_en = en[`ROLE_RD:`ROLE_SEL];
        strobes_next = strb_s & strb_en;
        rd_access = en[`ROLE_DATA] & strobes_next[0] & strobes_next[3] & ~strobes_next[2];
        data_oe_b_next = ~rd_access;
        data_out_next = rd_access ? core_rdata : `DATA_RST;
        wdata_next = en[`ROLE_DATA] ? data_s : `DATA_RST;
        // Ready is held low during a boot reset, whatever isolation says
        if (state_reg == ST_RESET && boot_mode_reg) begin
            rdy_out_next = 1'b0;
            rdy_oe_b_next = 1'b0;
        end else begin
            rdy_out_next = en[`ROLE_RDY] & seq_ready;
            rdy_oe_b_next = ~en[`ROLE_RDY];
        end
        irq_out_next = en[`ROLE_IRQ] & seq_irq;
        irq_oe_b_next = ~en[`ROLE_IRQ];
        xreq_out_next = en[`ROLE_XREQ] & seq_xfer_req;
        xreq_oe_b_next = ~en[`ROLE_XREQ];
        // Non-boot pins without a port role stay general inputs
        gp_strobe_next = boot_mode_reg ? `STROBE_RST : strb_s & ~role_on[`ROLE_RD:`ROLE_SEL];
        gp_data_next = (!boot_mode_reg && !role_on[`ROLE_DATA]) ? data_s : `DATA_RST;
        gp_iso_next = (!boot_mode_reg && !(state_reg == ST_RUN && pfc_iso_sel)) & iso_s;
    end

    // Every pin-side output is registered
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            host_ready_out <= 1'b0;
            host_ready_oe_b <= 1'b1;
            host_irq_out <= 1'b0;
            host_irq_oe_b <= 1'b1;
            host_xfer_req_out <= 1'b0;
            host_xfer_req_oe_b <= 1'b1;
            host_data_out <= `DATA_RST;
            host_data_oe_b <= 1'b1;
            core_strobes <= `STROBE_RST;
            core_wdata <= `DATA_RST;
            buf_enable <= `ROLE_RST;
            gp_strobe_in <= `STROBE_RST;
            gp_data_in <= `DATA_RST;
            gp_iso_in <= 1'b0;
            run_boot_mode <= 1'b0;
        end else begin
            host_ready_out <= rdy_out_next;
            host_ready_oe_b <= rdy_oe_b_next;
            host_irq_out <= irq_out_next;
            host_irq_oe_b <= irq_oe_b_next;
            host_xfer_req_out <= xreq_out_next;
            host_xfer_req_oe_b <= xreq_oe_b_next;
            host_data_out <= data_out_next;
            host_data_oe_b <= data_oe_b_next;
            core_strobes <= strobes_next;
            core_wdata <= wdata_next;
            buf_enable <= en;
            gp_strobe_in <= gp_strobe_next;
            gp_data_in <= gp_data_next;
            gp_iso_in <= gp_iso_next;
            run_boot_mode <= boot_mode_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_b);

    logic in_rst_boot, in_run_boot, in_run_nb;
    assign in_rst_boot = (state_reg == ST_RESET) && boot_mode_reg;
    assign in_run_boot = (state_reg == ST_RUN) && boot_mode_reg;
    assign in_run_nb = (state_reg == ST_RUN) && !boot_mode_reg;

    sequence s_boot_release;
        in_rst_boot ##1 (state_reg == ST_RUN);
    endsequence

    sequence s_all_off;
        host_irq_oe_b && host_xfer_req_oe_b && host_data_oe_b && (core_strobes == 4'h0);
    endsequence

    AST_BOOT_RESET_READY_LOW: assert property (in_rst_boot |=> !host_ready_out && !host_ready_oe_b)
        else $error("ready not driven low in boot reset");
    AST_BOOT_RESET_BUF_OFF: assert property (in_rst_boot |=> s_all_off)
        else $error("port buffers on during boot reset");
    AST_ISO_LOW_HIZ: assert property (in_run_boot && !iso_s |=> s_all_off ##0 host_ready_oe_b)
        else $error("buffers on while isolation low");
    AST_RELEASE_DRIVES: assert property (s_boot_release ##0 iso_s |=> !host_ready_oe_b && !host_irq_oe_b)
        else $error("outputs not enabled after boot release");
    AST_SEQ_FOLLOW: assert property (in_run_boot && iso_s |=> host_irq_out == $past(seq_irq) && host_xfer_req_out == $past(seq_xfer_req))
        else $error("outputs do not follow sequence values");
    AST_NONBOOT_RESET_GENERAL: assert property (!boot_mode_reg && state_reg == ST_RESET |=> buf_enable == 8'h00 && host_ready_oe_b)
        else $error("non-boot reset touched port buffers");
    AST_NO_ISO_ROLE_OFF: assert property (in_run_nb && !pfc_iso_sel |=> buf_enable == 8'h00)
        else $error("buffers on without isolation role");
    AST_ROLE_NEEDS_SELECT: assert property (in_run_nb && !pin_function_select[`ROLE_RDY] |=> host_ready_oe_b)
        else $error("ready driven without its role selected");
    AST_GATED_BY_ISO: assert property (in_run_nb && pfc_iso_sel && iso_s |=> buf_enable == $past(pin_function_select))
        else $error("selected buffers not enabled by isolation");
    AST_DATA_READ_ONLY: assert property (!host_data_oe_b |-> $past(strobes_next[0] && strobes_next[3] && !strobes_next[2]))
        else $error("data driven outside a selected read");

endmodule : host_port_pin_isolation
`default_nettype wire

// ---- tb/host_model.sv ----
// External host processor and its power monitor, as seen from the port pins
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"

module host_model (
    input wire logic clk_sys,
    input wire logic power_good,
    input wire logic [1:0] host_op,
    input wire logic regsel,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic [`DATA_W-1:0] host_data_out,
    input wire logic host_data_oe_b,
    output logic iso_enable_in,
    output logic host_select_in,
    output logic host_regsel_in,
    output logic host_write_strobe,
    output logic host_read_strobe,
    output logic [`DATA_W-1:0] host_data_in
);
    logic [`DATA_W-1:0] last_reg;
    // ****************************************************************
    // Power monitor and strobes; an unpowered host drives no strobe
    // ****************************************************************
    initial begin
        iso_enable_in = 1'b0;
        host_select_in = 1'b0;
        host_regsel_in = 1'b0;
        host_write_strobe = 1'b0;
        host_read_strobe = 1'b0;
        last_reg = 16'h0000;
    end
    always @(posedge clk_sys) begin
        iso_enable_in <= power_good;
        host_select_in <= power_good & (host_op != 2'h0);
        host_regsel_in <= power_good & regsel;
        host_write_strobe <= power_good & (host_op == 2'h2);
        host_read_strobe <= power_good & (host_op == 2'h1);
        last_reg <= host_data_in;
    end
    // Data wire: host write, device drive, else floating pattern
    assign host_data_in = host_write_strobe ? wdata
                        : (!host_data_oe_b ? host_data_out : ~last_reg);
endmodule : host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the host port pin isolation block
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"

module tb_top;
    logic clk_sys, rst_b, reset_pin_b, boot_select_in, pfc_iso_sel, power_good, regsel;
    logic iso_enable_in, seq_ready, seq_irq, seq_xfer_req, gp_iso_in, run_boot_mode;
    logic host_select_in, host_regsel_in, host_write_strobe, host_read_strobe;
    logic host_ready_out, host_ready_oe_b, host_irq_out, host_irq_oe_b;
    logic host_xfer_req_out, host_xfer_req_oe_b, host_data_oe_b;
    logic [1:0] host_op;
    logic [3:0] core_strobes, gp_strobe_in;
    logic [`ROLE_N-1:0] pin_function_select, buf_enable;
    logic [`DATA_W-1:0] core_rdata, wdata, host_data_in, host_data_out, core_wdata, gp_data_in;
    int miscompares = 0;
    int check_count = 0;

    host_port_pin_isolation dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .reset_pin_b(reset_pin_b), .boot_select_in(boot_select_in),
        .iso_enable_in(iso_enable_in), .pfc_iso_sel(pfc_iso_sel),
        .pin_function_select(pin_function_select), .seq_ready(seq_ready),
        .seq_irq(seq_irq), .seq_xfer_req(seq_xfer_req), .core_rdata(core_rdata),
        .host_ready_out(host_ready_out), .host_ready_oe_b(host_ready_oe_b),
        .host_irq_out(host_irq_out), .host_irq_oe_b(host_irq_oe_b),
        .host_xfer_req_out(host_xfer_req_out), .host_xfer_req_oe_b(host_xfer_req_oe_b),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe_b(host_data_oe_b), .host_select_in(host_select_in),
        .host_regsel_in(host_regsel_in), .host_write_strobe(host_write_strobe),
        .host_read_strobe(host_read_strobe), .core_strobes(core_strobes),
        .core_wdata(core_wdata), .buf_enable(buf_enable), .gp_strobe_in(gp_strobe_in),
        .gp_data_in(gp_data_in), .gp_iso_in(gp_iso_in), .run_boot_mode(run_boot_mode));

    host_model host_u (.clk_sys(clk_sys), .power_good(power_good), .host_op(host_op),
        .regsel(regsel), .wdata(wdata), .host_data_out(host_data_out),
        .host_data_oe_b(host_data_oe_b), .iso_enable_in(iso_enable_in),
        .host_select_in(host_select_in), .host_regsel_in(host_regsel_in),
        .host_write_strobe(host_write_strobe), .host_read_strobe(host_read_strobe),
        .host_data_in(host_data_in));

    // ****************************************************************
    // Clock, checking and closing
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Let pin filters settle, then sample past the edge
    task automatic wt();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : wt
    task automatic all_off(input string name);
        chk({name, " oe"}, {host_ready_oe_b, host_irq_oe_b, host_xfer_req_oe_b, host_data_oe_b},
            4'hf);
        chk({name, " strobes"}, core_strobes, 4'h0);
    endtask : all_off

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_boot_reset();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            power_good <= i[0];
            wt();
            chk("rdy oe", host_ready_oe_b, 1'b0);
            chk("rdy out", host_ready_out, 1'b0);
            chk("irq xreq data oe", {host_irq_oe_b, host_xfer_req_oe_b, host_data_oe_b}, 3'h7);
            chk("strobes", core_strobes, 4'h0);
        end
    endtask : t_boot_reset
    task automatic t_boot_run();
        @(posedge clk_sys);
        reset_pin_b <= 1'b1;
        wt();
        chk("boot mode", run_boot_mode, 1'b1);
        chk("seq outs", {host_ready_out, host_irq_out, host_xfer_req_out}, 3'h7);
        chk("seq oe", {host_ready_oe_b, host_irq_oe_b, host_xfer_req_oe_b}, 3'h0);
        chk("read drive", {host_data_oe_b, host_data_out}, 17'h05a3c);
        chk("read strobes", core_strobes, 4'h9);
        @(posedge clk_sys);
        host_op <= 2'h2;
        regsel <= 1'b1;
        wt();
        chk("write release", host_data_oe_b, 1'b1);
        chk("write data", core_wdata, 16'hc3a5);
        chk("write strobes", core_strobes, 4'h7);
    endtask : t_boot_run
    task automatic t_power_cut();
        @(posedge clk_sys);
        power_good <= 1'b0;
        host_op <= 2'h1;
        wt();
        all_off("cut");
        chk("cut en", buf_enable, 8'h00);
        chk("cut wdata", core_wdata, 16'h0000);
        @(posedge clk_sys);
        power_good <= 1'b1;
        wt();
        chk("restore", host_data_oe_b, 1'b0);
    endtask : t_power_cut
    task automatic t_nonboot();
        @(posedge clk_sys);
        reset_pin_b <= 1'b0;
        boot_select_in <= 1'b0;
        wt();
        all_off("nb reset");
        chk("nb rdy oe", host_ready_oe_b, 1'b1);
        chk("nb gp iso", gp_iso_in, 1'b1);
        @(posedge clk_sys);
        reset_pin_b <= 1'b1;
        pin_function_select <= 8'hff;
        wt();
        chk("nb mode", run_boot_mode, 1'b0);
        chk("no iso role en", buf_enable, 8'h00);
        all_off("no iso role");
        @(posedge clk_sys);
        pfc_iso_sel <= 1'b1;
        pin_function_select <= 8'h01;
        wt();
        chk("one role en", buf_enable, 8'h01);
        chk("one role oe", {host_ready_oe_b, host_irq_oe_b, host_data_oe_b}, 3'h3);
        chk("gp strobes", gp_strobe_in, 4'hb);
        chk("gp iso taken", gp_iso_in, 1'b0);
        // Strobe roles only: ready released, data pins stay general inputs
        @(posedge clk_sys);
        pin_function_select <= 8'hf0;
        host_op <= 2'h2;
        wt();
        chk("strobe roles en", buf_enable, 8'hf0);
        chk("strobe roles seen", core_strobes, 4'h7);
        chk("unselected rdy oe", host_ready_oe_b, 1'b1);
        chk("gp data", gp_data_in, 16'hc3a5);
        chk("gp strobes off", gp_strobe_in, 4'h0);
        chk("no data role wdata", core_wdata, 16'h0000);
        @(posedge clk_sys);
        power_good <= 1'b0;
        wt();
        chk("gated en", buf_enable, 8'h00);
    endtask : t_nonboot

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        rst_b = 1'b0;
        reset_pin_b = 1'b0;
        boot_select_in = 1'b1;
        pfc_iso_sel = 1'b0;
        power_good = 1'b0;
        regsel = 1'b0;
        host_op = 2'h1;
        wdata = 16'hc3a5;
        pin_function_select = 8'h00;
        {seq_ready, seq_irq, seq_xfer_req} = 3'h7;
        core_rdata = 16'h5a3c;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_boot_reset();
        t_boot_run();
        t_power_cut();
        t_nonboot();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
